//--- hw/sbh_bus_hold.sv
/*
 holds the bus command strobe engine and the hold/acknowledge handover logic.
 assumes external pins arrive asynchronously, core requests are on clk, and
 the pad ring or bench resolves wire levels from the output enables.
*/
//
// Overview of operation
// RL1 - drive memory read strobe, input under master
// RL2 - drive memory write strobe, input under master
// RL3 - wide targets pull feedback low open-collector
// RL4 - forced-wide chip select drives feedback low
// RL5 - master access internal/dram drives feedback low
// RL6 - ready low stretches our bus cycle
// RL7 - pull ready low for master internal accesses
// RL8 - master requests bus with hold high
// RL9 - master limits its own hold time
// RL10 - grant acknowledge driven low on handover
// RL11 - master drives address and strobes after grant
// RL12 - address enable low, high to float master
// RL13 - master floats addresses while enable high
// RL14 - upper byte enable becomes input under master
// RL15 - grant after cycle ends, hold until released
`timescale 1ns/1ps
`default_nettype none
module sbh_bus_hold
   import sbh_pkg::*;
#(
   parameter int STROBE_CYC = SBH_STROBE_CYC   // least strobe length in cycles
) (
   input  wire logic   clk,                    // system clock
   input  wire logic   reset,                  // synchronous, active high
   // core side request
   input  wire logic   cyc_req,                // start a cycle (level, held until done)
   input  wire logic [1:0] cyc_kind,           // sbh_cyc_t value
   input  wire logic   cyc_upper,              // access touches the upper byte
   input  wire logic   cyc_force16,            // chip select forces 16-bit width
   output logic        cyc_done,               // one-cycle pulse at cycle end
   output logic        cyc_wide,               // width seen at end of cycle
   // internal demand during a hold
   input  wire logic   int_target_hit,         // master decodes to our peripherals/dram
   input  wire logic   int_busy,               // internal side not ready for master
   input  wire logic   snoop_busy,             // cache snoop in progress
   input  wire logic   dram_need_addr,         // dram controller needs the address bus
   output logic        bus_owned_by_master,    // handover is in force
   // command strobes, three signals each
   input  wire logic   mem_read_cmd_n_i,
   output logic        mem_read_cmd_n_o,
   output logic        mem_read_cmd_n_oe,
   input  wire logic   mem_write_cmd_n_i,
   output logic        mem_write_cmd_n_o,
   output logic        mem_write_cmd_n_oe,
   input  wire logic   io_read_cmd_n_i,
   output logic        io_read_cmd_n_o,
   output logic        io_read_cmd_n_oe,
   input  wire logic   io_write_cmd_n_i,
   output logic        io_write_cmd_n_o,
   output logic        io_write_cmd_n_oe,
   input  wire logic   upper_byte_enable_n_i,
   output logic        upper_byte_enable_n_o,
   output logic        upper_byte_enable_n_oe,
   // open-drain feedback lines
   input  wire logic   wide_access_ack_n_i,
   output logic        wide_access_ack_n_o,
   output logic        wide_access_ack_n_oe,
   input  wire logic   ready_i,
   output logic        ready_o,
   output logic        ready_oe,
   // handover pins
   input  wire logic   hold_req,               // active high request from master
   output logic        bus_grant_ack_n,        // low while bus is granted
   output logic        master_addr_drive_ok_n  // low lets master drive addresses
);
   // ----------------------------------------------------------------
   // elaboration checks
   // ----------------------------------------------------------------
   if (STROBE_CYC < 1 || STROBE_CYC >= (1 << SBH_CNT_W)) begin : g_chk
      $error("STROBE_CYC out of range for counter");
   end

   typedef enum logic [2:0] {
      SBH_IDLE,          // bus free, own strobes idle
      SBH_STROBE,        // own command strobe active
      SBH_WAIT,          // minimum met, waiting for ready
      SBH_GRANTED        // master owns the bus
   } sbh_state_t;

   localparam logic [SBH_CNT_W-1:0] CNT_LAST = SBH_CNT_W'(STROBE_CYC - 1);
   localparam logic [SBH_CNT_W-1:0] CNT_ZERO = '0;

   sbh_state_t           state_q, state_d;     // main sequencer
   logic [SBH_CNT_W-1:0] cnt_q, cnt_d;         // strobe length counter
   logic [1:0]           kind_q;               // latched cycle kind
   logic                 upper_q;              // latched upper byte flag
   logic                 f16_q;                // latched forced-wide flag
   logic                 done_q, wide_q;       // answer flops
   logic                 grant_q;              // registered grant
   logic                 addr_ok_n_q;          // registered address enable
   logic                 wide_drv_q, rdy_drv_q;// open-drain pull-down requests
   logic [3:0]           cmd_n_q;              // {mem rd, mem wr, io rd, io wr}, low = on
   logic                 upper_n_q;            // upper byte enable, low = on
   logic                 drv_q;                // device drives the command lines
   logic                 grant_n_q;            // grant acknowledge pin level

   // synchronised pins: hold, ready, wide feedback, master strobes
   logic [6:0] pins_raw, pins_s;
   logic       hold_s, ready_s, wide_s, mrd_s, mwr_s, ird_s, iwr_s;

   assign pins_raw = {hold_req, ready_i, wide_access_ack_n_i, mem_read_cmd_n_i,
                      mem_write_cmd_n_i, io_read_cmd_n_i, io_write_cmd_n_i};
   assign {hold_s, ready_s, wide_s, mrd_s, mwr_s, ird_s, iwr_s} = pins_s;

   sbh_sync2 #(.WIDTH(7)) u_sync (
      .clk      (clk),
      .reset    (reset),
      .async_in (pins_raw),
      .rst_val  (7'h3f),           // hold idles low, the rest pulled up
      .sync_out (pins_s)
   );

   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   // master is running a command cycle of its own
   wire master_cmd = !(mrd_s & mwr_s & ird_s & iwr_s);
   // master cycle aimed at our internal side
   wire master_int = (state_q == SBH_GRANTED) && master_cmd && int_target_hit;
   // strobe minimum elapsed
   wire cnt_end    = (cnt_q == CNT_LAST);
   // width at cycle end: forced-wide is ours, others sample the pin
   wire wide_now   = f16_q | !wide_s;

   // ----------------------------------------------------------------
   // next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q;
      case (state_q)
         SBH_IDLE: begin
            // a pending hold wins over a new core cycle, since the bus is idle
            if (hold_s) begin
               state_d = SBH_GRANTED;                  // see RL15
            end else if (cyc_req) begin
               state_d = SBH_STROBE;
               cnt_d   = CNT_ZERO;
            end
         end
         SBH_STROBE: begin
            cnt_d = cnt_q + SBH_CNT_W'(1);
            if (cnt_end) begin
               state_d = SBH_WAIT;
            end
         end
         SBH_WAIT: begin
            // target holds ready low to add wait states
            if (ready_s) begin
               state_d = SBH_IDLE;                     // see RL6
            end
         end
         SBH_GRANTED: begin
            // release only when the master drops its request
            if (!hold_s) begin
               state_d = SBH_IDLE;                     // see RL15
            end
         end
         default: state_d = SBH_IDLE;
      endcase
   end

   wire end_cycle = (state_q == SBH_WAIT) && ready_s;
   wire start_cyc = (state_q == SBH_IDLE) && !hold_s && cyc_req;

   // next values of the pin flops; a new cycle uses the request, not the stale latch
   wire       strobe_d = (state_d == SBH_STROBE) || (state_d == SBH_WAIT);
   wire [1:0] kind_d   = start_cyc ? cyc_kind : kind_q;
   wire       upper_d  = start_cyc ? cyc_upper : upper_q;

   // active-low strobe pattern for one cycle kind
   function automatic logic [3:0] cmd_low(input logic [1:0] k);
      return ~(4'b1000 >> k);
   endfunction

   // ----------------------------------------------------------------
   // sequencer and latched request
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         state_q <= SBH_IDLE;
         cnt_q   <= CNT_ZERO;
         kind_q  <= 2'h0;
         upper_q <= 1'b0;
         f16_q   <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         if (start_cyc) begin
            kind_q  <= cyc_kind;
            upper_q <= cyc_upper;
            f16_q   <= cyc_force16;
         end
      end
   end

   // ----------------------------------------------------------------
   // output flops: strobes, answers, handover pins
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         cmd_n_q     <= {4{SBH_HIGH}};
         upper_n_q   <= SBH_HIGH;
         drv_q       <= 1'b1;
         grant_n_q   <= SBH_HIGH;
         done_q      <= 1'b0;
         wide_q      <= 1'b0;
         grant_q     <= 1'b0;
         addr_ok_n_q <= SBH_LOW;
         wide_drv_q  <= 1'b0;
         rdy_drv_q   <= 1'b0;
      end else begin
         cmd_n_q     <= strobe_d ? cmd_low(kind_d) : {4{SBH_HIGH}};   // see RL1, RL2
         upper_n_q   <= !(strobe_d && upper_d);                       // see RL14
         // strobes turn into inputs while the master owns the bus
         drv_q       <= (state_d != SBH_GRANTED);                     // see RL14
         grant_n_q   <= (state_d == SBH_GRANTED) ? SBH_LOW : SBH_HIGH; // see RL10
         done_q      <= end_cycle;
         wide_q      <= end_cycle ? wide_now : wide_q;
         grant_q     <= (state_d == SBH_GRANTED);                   // see RL10
         // float the master only while granted and dram needs the bus
         addr_ok_n_q <= (state_d == SBH_GRANTED && dram_need_addr)
                        ? SBH_HIGH : SBH_LOW;                       // see RL12
         // own forced-wide cycles, or master hitting internal targets
         wide_drv_q  <= (((state_d == SBH_STROBE) || (state_d == SBH_WAIT))
                         && (start_cyc ? cyc_force16 : f16_q))      // see RL4
                        || master_int;                              // see RL5
         // stretch the master while the internal side or a snoop is busy
         rdy_drv_q   <= (state_q == SBH_GRANTED)
                        && ((master_int && int_busy) || snoop_busy);// see RL7
      end
   end

   // ----------------------------------------------------------------
   // pin drive; strobes become inputs while granted
   // ----------------------------------------------------------------
   assign mem_read_cmd_n_o      = cmd_n_q[3];                       // see RL1
   assign mem_read_cmd_n_oe     = drv_q;                            // see RL1
   assign mem_write_cmd_n_o     = cmd_n_q[2];                       // see RL2
   assign mem_write_cmd_n_oe    = drv_q;                            // see RL2
   assign io_read_cmd_n_o       = cmd_n_q[1];
   assign io_read_cmd_n_oe      = drv_q;
   assign io_write_cmd_n_o      = cmd_n_q[0];
   assign io_write_cmd_n_oe     = drv_q;
   assign upper_byte_enable_n_o = upper_n_q;
   assign upper_byte_enable_n_oe = drv_q;                           // see RL14
   // open drain: drive low only, a pull-up makes the high (wide targets: see RL3)
   assign wide_access_ack_n_o   = SBH_LOW;
   assign wide_access_ack_n_oe  = wide_drv_q;
   assign ready_o               = SBH_LOW;
   assign ready_oe              = rdy_drv_q;
   assign bus_grant_ack_n       = grant_n_q;
   assign master_addr_drive_ok_n = addr_ok_n_q;                     // see RL13
   assign bus_owned_by_master   = grant_q;
   assign cyc_done              = done_q;
   assign cyc_wide              = wide_q;
endmodule // sbh_bus_hold
`default_nettype wire

//--- hw/sbh_pkg.sv
/*
 holds the shared constants and types of the system bus hold handover block.
 assumes a single 50 MHz clock; no software-visible registers exist.
*/
package sbh_pkg;
   // ----------------------------------------------------------------
   // cycle kinds requested by the internal core side
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      SBH_CYC_MEM_RD,
      SBH_CYC_MEM_WR,
      SBH_CYC_IO_RD,
      SBH_CYC_IO_WR
   } sbh_cyc_t;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int  SBH_CLK_MHZ      = 50;      // system clock rate
   localparam int  SBH_STROBE_NS    = 120;     // least command strobe width
   localparam int  SBH_STROBE_CYC   = (SBH_STROBE_NS * SBH_CLK_MHZ + 999) / 1000;
   localparam int  SBH_CNT_W        = 8;       // width of the strobe counter
   localparam logic SBH_LOW         = 1'b0;    // asserted level of _n lines
   localparam logic SBH_HIGH        = 1'b1;    // released level of _n lines
endpackage : sbh_pkg

//--- hw/sbh_sync2.sv
/*
 holds a two flip-flop synchroniser for a bundle of asynchronous pin levels.
 assumes the inputs change no faster than the clock can follow.
*/
`timescale 1ns/1ps
`default_nettype none
module sbh_sync2 #(
   parameter int WIDTH = 1                 // number of levels carried
) (
   input  wire logic             clk,      // system clock
   input  wire logic             reset,    // synchronous, active high
   input  wire logic [WIDTH-1:0] async_in, // raw pin levels
   input  wire logic [WIDTH-1:0] rst_val,  // idle level of each pin
   output logic      [WIDTH-1:0] sync_out  // levels safe to read
);
   logic [WIDTH-1:0] meta_q;               // first stage, read only by stage two
   logic [WIDTH-1:0] sync_q;               // second stage

   // ----------------------------------------------------------------
   // two stages; reset loads rst_val, the idle level of each pin
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         meta_q <= rst_val;
         sync_q <= rst_val;
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end

   assign sync_out = sync_q;
endmodule // sbh_sync2
`default_nettype wire

//--- testbench/sbh_checker.sv
/*
 concurrent checks on the ports of the bus hold handover block.
 assumes one clock, synchronous reset and the bench's pin resolution.
*/
`timescale 1ns/1ps
`default_nettype none
module sbh_checker #(
   parameter int STROBE_CYC = 6            // repetition below assumes 6
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic cyc_req,
   input wire logic cyc_force16,
   input wire logic cyc_upper,
   input wire logic cyc_done,
   input wire logic snoop_busy,
   input wire logic dram_need_addr,
   input wire logic hold_req,
   input wire logic ready_i,
   input wire logic mem_read_cmd_n_o,
   input wire logic mem_read_cmd_n_oe,
   input wire logic mem_write_cmd_n_o,
   input wire logic mem_write_cmd_n_oe,
   input wire logic io_read_cmd_n_o,
   input wire logic io_write_cmd_n_o,
   input wire logic upper_byte_enable_n_o,
   input wire logic upper_byte_enable_n_oe,
   input wire logic wide_access_ack_n_oe,
   input wire logic ready_oe,
   input wire logic bus_grant_ack_n,
   input wire logic master_addr_drive_ok_n
);
   // the fixed repetition in the strobe length check needs at least this many
   if (STROBE_CYC < 5) begin : g_len
      $error("STROBE_CYC below the fixed repetition count");
   end
   // ----------------------------------------------------------------
   // helpers and properties
   // ----------------------------------------------------------------
   // one of our own command strobes is on the wire
   wire core_low = mem_read_cmd_n_oe && !(mem_read_cmd_n_o && mem_write_cmd_n_o
                   && io_read_cmd_n_o && io_write_cmd_n_o);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   a_grant_after_hold: assert property ($fell(bus_grant_ack_n) |-> $past(hold_req, 3))
      else $error("grant without a hold request");
   a_master_owns_cmds: assert property (!bus_grant_ack_n |-> !mem_read_cmd_n_oe
      && !mem_write_cmd_n_oe && !upper_byte_enable_n_oe) else $error("strobe driven in hold");
   a_addr_en_low: assert property (bus_grant_ack_n && $past(bus_grant_ack_n)
      |-> !master_addr_drive_ok_n) else $error("address enable high outside hold");
   a_addr_float_high: assert property (!bus_grant_ack_n && !$past(bus_grant_ack_n)
      && $past(dram_need_addr) |-> master_addr_drive_ok_n) else $error("master not floated");
   a_wide_forced_on: assert property (core_low && cyc_req && cyc_force16
      |-> wide_access_ack_n_oe) else $error("forced width not signalled");
   a_wide_not_forced: assert property (core_low && !cyc_force16 |-> !wide_access_ack_n_oe)
      else $error("width pulled without force");
   a_ready_own_idle: assert property (bus_grant_ack_n && $past(bus_grant_ack_n)
      |-> !ready_oe) else $error("ready pulled in own cycle");
   a_ready_snoop_wait: assert property (!bus_grant_ack_n && !$past(bus_grant_ack_n)
      && $past(snoop_busy) |-> ready_oe) else $error("snoop did not hold ready");
   a_ready_stretches: assert property ((!ready_i) [*4] |=> !cyc_done)
      else $error("cycle ended while not ready");
   a_strobe_min_len: assert property (core_low && !$past(core_low) |-> core_low [*6])
      else $error("strobe too short");
   a_upper_follows: assert property (core_low && cyc_req
      |-> upper_byte_enable_n_o == !cyc_upper) else $error("upper enable wrong");
   // main scenarios reached
   c_float: cover property (!bus_grant_ack_n && master_addr_drive_ok_n);
   c_forced: cover property (cyc_done && cyc_force16);
   c_ready: cover property ($rose(ready_oe));
endmodule // sbh_checker

bind sbh_bus_hold sbh_checker #(.STROBE_CYC(STROBE_CYC)) chk (.clk(clk), .reset(reset),
   .cyc_req(cyc_req), .cyc_force16(cyc_force16), .cyc_upper(cyc_upper),
   .cyc_done(cyc_done), .snoop_busy(snoop_busy), .dram_need_addr(dram_need_addr),
   .hold_req(hold_req), .ready_i(ready_i), .mem_read_cmd_n_o(mem_read_cmd_n_o),
   .mem_read_cmd_n_oe(mem_read_cmd_n_oe), .mem_write_cmd_n_o(mem_write_cmd_n_o),
   .mem_write_cmd_n_oe(mem_write_cmd_n_oe), .io_read_cmd_n_o(io_read_cmd_n_o),
   .io_write_cmd_n_o(io_write_cmd_n_o), .upper_byte_enable_n_o(upper_byte_enable_n_o),
   .upper_byte_enable_n_oe(upper_byte_enable_n_oe),
   .wide_access_ack_n_oe(wide_access_ack_n_oe), .ready_oe(ready_oe),
   .bus_grant_ack_n(bus_grant_ack_n), .master_addr_drive_ok_n(master_addr_drive_ok_n));
`default_nettype wire

//--- testbench/sbh_far_end.sv
/*
 behavioural model of the external master and an isa-type target.
 assumes the bench resolves open-drain and pulled-up lines from its outputs.
*/
`timescale 1ns/1ps
`default_nettype none
module sbh_far_end (
   input  wire logic       clk,        // system clock
   input  wire logic       grant_n,    // grant acknowledge from the device
   input  wire logic       addr_ok_n,  // address enable from the device
   input  wire logic       strobe_n,   // and of our command pins, 1 in hold
   input  wire logic       want_hold,  // bench asks for the bus
   input  wire logic       m_read,     // master reads while it owns the bus
   input  wire logic [3:0] waits,      // wait states the target inserts
   input  wire logic       wide,       // target is 16 bits wide
   output logic            hold_req,   // request pin
   output logic            m_drive,    // master drives the command lines
   output logic            m_rd_n,     // master read strobe
   output logic            m_addr_oe,  // master address drivers on
   output logic            rdy_pull,   // target pulls ready low
   output logic            wide_pull   // target pulls width feedback low
);
   logic [3:0] cnt_q;                  // saturating count from strobe start
   assign m_drive   = !grant_n;
   assign m_addr_oe = !grant_n && !addr_ok_n;
   assign wide_pull = wide && !strobe_n;
   assign rdy_pull  = !strobe_n && (cnt_q < waits);
   // request follows the bench; strobes only start after the grant
   always_ff @(posedge clk) begin
      hold_req <= want_hold;
      m_rd_n   <= !(m_read && !grant_n);
      cnt_q    <= strobe_n ? 4'h0 : cnt_q + {3'h0, cnt_q != 4'hf};
   end
endmodule // sbh_far_end
`default_nettype wire

//--- testbench/tb.sv
/*
 self-checking bench for the bus hold handover block.
 assumes pull-ups on all command, width and ready lines.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_errors++; \
   $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module tb;
   import sbh_pkg::*;
   logic clk = 0, reset = 1, cyc_req = 0, upper = 0, f16 = 0, int_hit = 0;
   logic int_busy = 0, snoop = 0, dram_need = 0, want_hold = 0, m_read = 0, wide = 0;
   logic [1:0] kind = 2'h0;
   logic [3:0] waits = 4'h0;
   logic cyc_done, cyc_wide, owned, mr_o, mr_oe, mw_o, mw_oe, ir_o, ir_oe, iw_o, iw_oe;
   logic ub_o, ub_oe, wd_o, wd_oe, rd_o, rd_oe, grant_n, addr_ok_n;
   logic hold_req, m_drive, m_rd_n, m_addr_oe, rdy_pull, wide_pull;
   int n_errors = 0, num_checks = 0, cycles = 0, i;
   // ----------------------------------------------------------------
   // wire resolution: device, master, pull-ups
   // ----------------------------------------------------------------
   wire mr_pin = mr_oe ? mr_o : (m_drive ? m_rd_n : 1'b1);
   wire mw_pin = mw_oe ? mw_o : 1'b1;   // master only reads here
   wire ir_pin = ir_oe ? ir_o : 1'b1;
   wire iw_pin = iw_oe ? iw_o : 1'b1;
   wire ub_pin = ub_oe ? ub_o : 1'b1;
   wire wd_pin = !((wd_oe && !wd_o) || wide_pull);
   wire rdy_pin = !((rd_oe && !rd_o) || rdy_pull);
   wire strobe_n = (mr_pin && mw_pin && ir_pin && iw_pin) || !grant_n;
   always #10 clk = ~clk;
   sbh_bus_hold DUT (.clk(clk), .reset(reset), .cyc_req(cyc_req), .cyc_kind(kind),
      .cyc_upper(upper), .cyc_force16(f16), .cyc_done(cyc_done), .cyc_wide(cyc_wide),
      .int_target_hit(int_hit), .int_busy(int_busy), .snoop_busy(snoop),
      .dram_need_addr(dram_need), .bus_owned_by_master(owned),
      .mem_read_cmd_n_i(mr_pin), .mem_read_cmd_n_o(mr_o), .mem_read_cmd_n_oe(mr_oe),
      .mem_write_cmd_n_i(mw_pin), .mem_write_cmd_n_o(mw_o), .mem_write_cmd_n_oe(mw_oe),
      .io_read_cmd_n_i(ir_pin), .io_read_cmd_n_o(ir_o), .io_read_cmd_n_oe(ir_oe),
      .io_write_cmd_n_i(iw_pin), .io_write_cmd_n_o(iw_o), .io_write_cmd_n_oe(iw_oe),
      .upper_byte_enable_n_i(ub_pin), .upper_byte_enable_n_o(ub_o),
      .upper_byte_enable_n_oe(ub_oe), .wide_access_ack_n_i(wd_pin),
      .wide_access_ack_n_o(wd_o), .wide_access_ack_n_oe(wd_oe), .ready_i(rdy_pin),
      .ready_o(rd_o), .ready_oe(rd_oe), .hold_req(hold_req), .bus_grant_ack_n(grant_n),
      .master_addr_drive_ok_n(addr_ok_n));
   sbh_far_end far (.clk(clk), .grant_n(grant_n), .addr_ok_n(addr_ok_n), .strobe_n(strobe_n),
      .want_hold(want_hold), .m_read(m_read), .waits(waits), .wide(wide),
      .hold_req(hold_req), .m_drive(m_drive), .m_rd_n(m_rd_n), .m_addr_oe(m_addr_oe),
      .rdy_pull(rdy_pull), .wide_pull(wide_pull));
   // expected command pins {mem rd, mem wr, io rd, io wr} for one kind
   function automatic logic [3:0] exp_pins(input logic [1:0] k);
      return ~(4'b1000 >> k);
   endfunction
   task automatic results();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // one core cycle; request dropped in the same cycle as the done pulse
   task automatic core_cycle(input logic [1:0] k, input logic f, input logic u,
                             input logic [3:0] w, input logic wd);
      int t;
      @(negedge clk);
      kind = k; f16 = f; upper = u; waits = w; wide = wd; cyc_req = 1'b1;
      for (t = 0; t < 60 && cyc_done !== 1'b1; t++) begin
         @(negedge clk);
         if (t == 2) `CHK({mr_pin, mw_pin, ir_pin, iw_pin}, exp_pins(k))
         if (t == 2) `CHK(ub_pin, !u)
      end
      `CHK(cyc_done, 1'b1)
      `CHK(cyc_wide, f | wd)
      cyc_req = 1'b0;
   endtask
   // hang guard, well above the few hundred cycles the run needs
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         results();
      end
   end
   initial begin
      repeat (12) @(negedge clk);
      reset = 1'b0;
      `CHK({grant_n, addr_ok_n, wd_oe, rd_oe, mr_oe}, 5'h11)
      void'($urandom(32'hc72c9e35));
      for (i = 0; i < 4; i++) core_cycle(2'(i), i[0], i[1], 4'h0, 1'b0);
      for (i = 0; i < 4; i++) core_cycle(2'(i), 1'b0, 1'b1, 4'hf, 1'b1);
      repeat (12) core_cycle(2'($urandom_range(3)), 1'($urandom_range(1)),
         1'($urandom_range(1)), 4'($urandom_range(15)), 1'($urandom_range(1)));
      // hold raised in mid cycle: grant only once the cycle is over
      fork
         core_cycle(2'h0, 1'b1, 1'b0, 4'h9, 1'b0);
         begin repeat (3) @(negedge clk); want_hold = 1'b1; end
      join
      for (i = 0; i < 20 && grant_n !== 1'b0; i++) @(negedge clk);
      `CHK({grant_n, mr_oe, owned}, 3'h1)
      m_read = 1'b1; int_hit = 1'b1; int_busy = 1'b1; dram_need = 1'b1;
      repeat (6) @(negedge clk);
      `CHK({mr_pin, wd_oe, rd_oe, addr_ok_n, m_addr_oe}, 5'h0e)
      int_busy = 1'b0; dram_need = 1'b0; snoop = 1'b1;
      repeat (3) @(negedge clk);
      `CHK({rd_oe, addr_ok_n, m_addr_oe}, 3'h5)
      snoop = 1'b0; m_read = 1'b0; int_hit = 1'b0;
      kind = 2'h1; f16 = 1'b0; waits = 4'h0; wide = 1'b0; cyc_req = 1'b1;
      repeat (6) @(negedge clk);
      `CHK({wd_oe, rd_oe, mw_pin, cyc_done}, 4'h2)
      want_hold = 1'b0;
      for (i = 0; i < 60 && cyc_done !== 1'b1; i++) @(negedge clk);
      `CHK({cyc_done, grant_n}, 2'h3)
      cyc_req = 1'b0;
      results();
   end
endmodule // tb
`default_nettype wire
